/* File: design/cprot_ctrl.sv */
// Channel protection, inrush retry, pair sync and PWM control top.
// Contract
// - Two independent PWM generators, own settings.
// - Four-bit trim code sets base frequency.
// - Overload latches channel off until host clear.
// - Retry mode restarts latched channel after delay.
// - Restart counter starts when channel switches on.
// - Commanded switch-off clears the retry enable, except in a cycle that writes the retry register.
// - Retry mode flags errors without latching off.
// - Timer clears retry enable after forty ms.
// - Retry mode selectable per channel.
// - Synced pair partner also switches off.
// - Sync bits pair 0-2, 1-3, 4-6, 5-7.
// - Sync affects only protection shut-off.
// - Inverse current holds channel on/off state.
// - Inverse current: error only if on and hot.
// - No protection on channel under inverse current.
// - Channels 2,3 pick behaviour from potentials.
// - New duty applies from the next period.
// - Duty is eight bits, max 255/256.
// - Divider 1024, 512, 256, or full on.
// - Any channel maps to either generator.
//
// Strobed register access and the register addresses are this design's own decisions.
module cprot_ctrl #(
  parameter int unsigned TMO_CYC     = cprot_pkg::INRUSH_TMO_CYC,
  parameter int unsigned RESTART_CYC = cprot_pkg::INRUSH_RESTART_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] ovl_det,
  input  wire logic [7:0] ot_det,
  input  wire logic [7:0] inv_det,
  input  wire logic [1:0] ovl_hs_det,
  input  wire logic [1:0] hs_sense,
  input  wire logic [7:0] in_pin,
  output logic      [7:0] ch_on
);

  localparam int unsigned TW = $clog2(TMO_CYC + 1);
  localparam int unsigned RW = $clog2(RESTART_CYC + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TMO_CYC - 1);
  localparam logic [RW-1:0] RST_LAST = RW'(RESTART_CYC - 1);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [35:0] sync1_q, sync2_q;
  logic [7:0]  ovl_s, ot_s, inv_s, in_s;
  logic [1:0]  ovl_hs_s, hs_s;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_q <= 36'h0;
      sync2_q <= 36'h0;
    end else begin
      sync1_q <= {hs_sense, ovl_hs_det, in_pin, inv_det, ot_det, ovl_det};
      sync2_q <= sync1_q;
    end
  end

  assign {hs_s, ovl_hs_s, in_s, inv_s, ot_s, ovl_s} = sync2_q;

  // ************************************************************
  // Software registers
  // ************************************************************
  logic [7:0]      out_cmd_q, out_cmd_d, pwm_en_q, pwm_en_d, map_q, map_d;
  logic [3:0]      pair_q, pair_d, trim_q, trim_d;
  logic [1:0][7:0] duty_q, duty_d;
  logic [1:0][1:0] div_q, div_d;
  logic [7:0]      rdata_q, rdata_d, ocl_wr;
  logic            retry_wr;

  // State of each channel, declared here for the read path.
  logic [7:0] on_q, latch_q, auto_q, err_q, retry_q;

  always_comb begin
    out_cmd_d = out_cmd_q;
    pwm_en_d  = pwm_en_q;
    map_d     = map_q;
    pair_d    = pair_q;
    trim_d    = trim_q;
    duty_d    = duty_q;
    div_d     = div_q;
    ocl_wr    = 8'h00;
    retry_wr  = 1'b0;
    rdata_d   = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        cprot_pkg::ADDR_OUT:     out_cmd_d = reg_wdata;
        cprot_pkg::ADDR_RETRY:   retry_wr = 1'b1;
        cprot_pkg::ADDR_PAIR:    pair_d = reg_wdata[3:0];
        cprot_pkg::ADDR_OCL:     ocl_wr = reg_wdata;
        cprot_pkg::ADDR_TRIM:    trim_d = reg_wdata[3:0];
        cprot_pkg::ADDR_DUTY0:   duty_d[0] = reg_wdata;
        cprot_pkg::ADDR_DIV0:    div_d[0] = reg_wdata[1:0];
        cprot_pkg::ADDR_DUTY1:   duty_d[1] = reg_wdata;
        cprot_pkg::ADDR_DIV1:    div_d[1] = reg_wdata[1:0];
        cprot_pkg::ADDR_PWM_EN:  pwm_en_d = reg_wdata;
        cprot_pkg::ADDR_PWM_MAP: map_d = reg_wdata;
        default:                 ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        cprot_pkg::ADDR_OUT:     rdata_d = out_cmd_q;
        cprot_pkg::ADDR_RETRY:   rdata_d = retry_q;
        cprot_pkg::ADDR_PAIR:    rdata_d = {4'h0, pair_q};
        cprot_pkg::ADDR_ERR:     rdata_d = err_q;
        cprot_pkg::ADDR_TRIM:    rdata_d = {4'h0, trim_q};
        cprot_pkg::ADDR_DUTY0:   rdata_d = duty_q[0];
        cprot_pkg::ADDR_DIV0:    rdata_d = {6'h00, div_q[0]};
        cprot_pkg::ADDR_DUTY1:   rdata_d = duty_q[1];
        cprot_pkg::ADDR_DIV1:    rdata_d = {6'h00, div_q[1]};
        cprot_pkg::ADDR_PWM_EN:  rdata_d = pwm_en_q;
        cprot_pkg::ADDR_PWM_MAP: rdata_d = map_q;
        cprot_pkg::ADDR_STATE:   rdata_d = on_q;
        cprot_pkg::ADDR_LATCH:   rdata_d = latch_q | auto_q;
        default:                 rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_cmd_q <= 8'h00;
      pwm_en_q  <= 8'h00;
      map_q     <= 8'h00;
      pair_q    <= 4'h0;
      trim_q    <= cprot_pkg::TRIM_RST;
      duty_q    <= {2{cprot_pkg::DUTY_RST}};
      div_q     <= {2{cprot_pkg::DIV_RST}};
      rdata_q   <= 8'h00;
    end else begin
      out_cmd_q <= out_cmd_d;
      pwm_en_q  <= pwm_en_d;
      map_q     <= map_d;
      pair_q    <= pair_d;
      trim_q    <= trim_d;
      duty_q    <= duty_d;
      div_q     <= div_d;
      rdata_q   <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ************************************************************
  // Trimmed base oscillator and PWM generators
  // ************************************************************
  logic [15:0] acc_q, acc_d;
  logic        tick_q, tick_d;
  logic [1:0]  pwm_lvl;

  always_comb begin
    {tick_d, acc_d} = {1'b0, acc_q} + {1'b0, cprot_pkg::trim_inc(trim_q)};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      tick_q <= tick_d;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_pwm
    cprot_pwm_gen u_pwm (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .base_tick (tick_q),
      .duty      (duty_q[g]),
      .div_sel   (div_q[g]),
      .pwm_q     (pwm_lvl[g])
    );
  end

  // ************************************************************
  // Channel protection and inrush retry
  // ************************************************************
  logic [7:0]          on_d, latch_d, auto_d, err_d, retry_d, cmd_q, cmd_d;
  logic [7:0]          ovl_eff, fault, kill, off_evt, on_evt, restart, tmo_hit;
  logic [7:0][TW-1:0]  tmo_q, tmo_d;
  logic [7:0][RW-1:0]  rc_q, rc_d;

  always_comb begin
    ovl_eff    = ovl_s;
    ovl_eff[2] = hs_s[0] ? ovl_hs_s[0] : ovl_s[2];
    ovl_eff[3] = hs_s[1] ? ovl_hs_s[1] : ovl_s[3];
    for (int i = 0; i < 8; i++) begin
      cmd_d[i] = out_cmd_q[i] | in_s[i] | (pwm_en_q[i] & pwm_lvl[map_q[i]]);
      fault[i] = on_q[i] & (ovl_eff[i] | ot_s[i]) & ~inv_s[i];
    end
    for (int i = 0; i < 8; i++) begin
      kill[i] = fault[i] | (pair_q[cprot_pkg::pair_idx(3'(i))]
                & fault[cprot_pkg::partner(3'(i))] & ~inv_s[i]);
      off_evt[i] = cmd_q[i] & ~cmd_d[i];
      on_evt[i]  = ~cmd_q[i] & cmd_d[i];
      tmo_hit[i] = retry_q[i] & (tmo_q[i] == TMO_LAST);
      restart[i] = auto_q[i] & retry_q[i] & (rc_q[i] == RST_LAST);
      retry_d[i] = retry_q[i] & ~off_evt[i] & ~tmo_hit[i];
      if (retry_wr) begin
        retry_d[i] = reg_wdata[i];
      end
      tmo_d[i] = (retry_q[i] && !retry_wr) ? tmo_q[i] + TW'(1) : '0;
      if (on_evt[i] || restart[i]) begin
        rc_d[i] = '0;
      end else if (cmd_q[i] && rc_q[i] != RST_LAST) begin
        rc_d[i] = rc_q[i] + RW'(1);
      end else begin
        rc_d[i] = rc_q[i];
      end
      auto_d[i]  = retry_q[i] & ~off_evt[i] & ((auto_q[i] & ~restart[i]) | kill[i]);
      latch_d[i] = (latch_q[i] & ~ocl_wr[i]) | (kill[i] & ~retry_q[i])
                   | (auto_q[i] & ~retry_q[i]);
      err_d[i]   = (err_q[i] & ~ocl_wr[i]) | kill[i]
                   | (inv_s[i] & on_q[i] & ot_s[i]);
      on_d[i]    = inv_s[i] ? on_q[i]
                   : cmd_d[i] & ~latch_d[i] & ~auto_d[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      on_q    <= 8'h00;
      latch_q <= 8'h00;
      auto_q  <= 8'h00;
      err_q   <= 8'h00;
      retry_q <= 8'h00;
      cmd_q   <= 8'h00;
      tmo_q   <= '0;
      rc_q    <= '0;
    end else begin
      on_q    <= on_d;
      latch_q <= latch_d;
      auto_q  <= auto_d;
      err_q   <= err_d;
      retry_q <= retry_d;
      cmd_q   <= cmd_d;
      tmo_q   <= tmo_d;
      rc_q    <= rc_d;
    end
  end

  assign ch_on = on_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  for (genvar c = 0; c < 8; c++) begin : g_chk
    localparam logic [2:0] PC = cprot_pkg::partner(3'(c));
    localparam logic [1:0] PB = cprot_pkg::pair_idx(3'(c));
    sequence s_fault_in_retry;
      fault[c] && retry_q[c] && !off_evt[c];
    endsequence
    sequence s_auto_off;
      auto_q[c] && !on_q[c];
    endsequence
    sequence s_count_done;
      rc_q[c] == RST_LAST && retry_q[c] && !kill[c] && !off_evt[c];
    endsequence

    a_latch_holds: assert property (
      latch_q[c] && !ocl_wr[c] && !inv_s[c] |=> !on_q[c] && latch_q[c])
      else $error("latched channel did not stay off");
    a_clear_unlatch: assert property (
      ocl_wr[c] && !kill[c] && !auto_q[c] |=> !latch_q[c])
      else $error("latch clear did not release channel");
    a_off_clears_retry: assert property (
      off_evt[c] && !retry_wr |=> !retry_q[c])
      else $error("switch-off left retry enabled");
    a_retry_no_latch: assert property (
      retry_q[c] && !latch_q[c] |=> !latch_q[c])
      else $error("retry mode latched channel");
    a_retry_timeout: assert property (
      retry_q[c] && tmo_q[c] == TMO_LAST && !retry_wr |=> !retry_q[c])
      else $error("retry timeout did not clear enable");
    a_inverse_hold: assert property (
      inv_s[c] |=> on_q[c] == $past(on_q[c]))
      else $error("inverse current changed channel state");
    a_inverse_noprot: assert property (
      inv_s[c] && !latch_q[c] && !ocl_wr[c] |=> !latch_q[c] || $past(auto_q[c]))
      else $error("protection acted under inverse current");
    a_pair_shutoff: assert property (
      fault[c] && pair_q[PB] && !inv_s[PC] |=> (latch_q[PC] || auto_q[PC]
      || $past(off_evt[PC])))
      else $error("partner channel not switched off");
    a_err_on_fault: assert property (
      kill[c] |=> err_q[c])
      else $error("fault did not set error flag");
    a_auto_restart: assert property (
      s_auto_off ##0 s_count_done |=> !auto_q[c])
      else $error("auto restart did not release channel");

    a_retry_auto_off: assert property (
      s_fault_in_retry |=> s_auto_off)
      else $error("fault in retry mode did not switch channel off");

    a_restart_count: assert property (
      on_evt[c] |=> rc_q[c] == '0)
      else $error("restart counter not started at switch-on");

    a_err_inverse_only: assert property (
      !err_q[c] && !kill[c] && !(inv_s[c] && on_q[c] && ot_s[c]) |=> !err_q[c])
      else $error("error flag set without a cause");

    a_no_self_on: assert property (
      !cmd_d[c] && !inv_s[c] |=> !on_q[c])
      else $error("channel switched on without its own command");

    a_kill_latches: assert property (
      kill[c] && !retry_q[c] |=> latch_q[c] && !on_q[c])
      else $error("fault did not latch channel off");

    a_tmo_idle: assert property (
      !retry_q[c] |=> tmo_q[c] == '0)
      else $error("timeout counter ran without retry mode");

    a_err_holds: assert property (
      err_q[c] && !ocl_wr[c] |=> err_q[c])
      else $error("error flag dropped without a clear");
  end

endmodule // cprot_ctrl

/* File: design/cprot_pkg.sv */
// Shared constants and helpers for the channel protection and PWM block.
package cprot_pkg;

  // ************************************************************
  // Geometry and register map
  // ************************************************************
  localparam int unsigned CH_N   = 8;
  localparam int unsigned REG_AW = 4;
  localparam int unsigned REG_DW = 8;

  localparam logic [3:0] ADDR_OUT     = 4'h0;
  localparam logic [3:0] ADDR_RETRY   = 4'h1;
  localparam logic [3:0] ADDR_PAIR    = 4'h2;
  localparam logic [3:0] ADDR_OCL     = 4'h3;
  localparam logic [3:0] ADDR_ERR     = 4'h4;
  localparam logic [3:0] ADDR_TRIM    = 4'h5;
  localparam logic [3:0] ADDR_DUTY0   = 4'h6;
  localparam logic [3:0] ADDR_DIV0    = 4'h7;
  localparam logic [3:0] ADDR_DUTY1   = 4'h8;
  localparam logic [3:0] ADDR_DIV1    = 4'h9;
  localparam logic [3:0] ADDR_PWM_EN  = 4'ha;
  localparam logic [3:0] ADDR_PWM_MAP = 4'hb;
  localparam logic [3:0] ADDR_STATE   = 4'hc;
  localparam logic [3:0] ADDR_LATCH   = 4'hd;

  localparam logic [3:0] TRIM_RST = 4'h8;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [1:0] DIV_RST  = 2'h0;

  // ************************************************************
  // Divider codes and timing
  // ************************************************************
  localparam logic [1:0] DIV_1024 = 2'h0;
  localparam logic [1:0] DIV_512  = 2'h1;
  localparam logic [1:0] DIV_256  = 2'h2;
  localparam logic [1:0] DIV_FULL = 2'h3;

  localparam int unsigned CLK_MHZ            = 100;
  localparam int unsigned INRUSH_TMO_MS      = 40;
  localparam int unsigned INRUSH_TMO_CYC     = INRUSH_TMO_MS * 1000 * CLK_MHZ;
  localparam int unsigned INRUSH_RESTART_US  = 200;
  localparam int unsigned INRUSH_RESTART_CYC = INRUSH_RESTART_US * CLK_MHZ;

  // Phase increment of the base oscillator for each trim code.
  function automatic logic [15:0] trim_inc(input logic [3:0] code);
    case (code)
      4'h1:    return 16'h0a0c;
      4'h2:    return 16'h0ae5;
      4'h3:    return 16'h0bb2;
      4'h4:    return 16'h0ca4;
      4'h5:    return 16'h0d85;
      4'h6:    return 16'h0e42;
      4'h7:    return 16'h0f12;
      4'h9:    return 16'h10b0;
      4'ha:    return 16'h116d;
      4'hb:    return 16'h123d;
      4'hc:    return 16'h131f;
      4'hd:    return 16'h1419;
      4'he:    return 16'h152f;
      4'hf:    return 16'h1666;
      default: return 16'h1000;
    endcase
  endfunction

  // Pair sync bit that links a channel to its partner.
  function automatic logic [1:0] pair_idx(input logic [2:0] ch);
    return {ch[2], ch[0]};
  endfunction

  function automatic logic [2:0] partner(input logic [2:0] ch);
    return ch ^ 3'h2;
  endfunction

endpackage

/* File: design/cprot_pwm_gen.sv */
// One PWM generator running on ticks of the trimmed base oscillator.
module cprot_pwm_gen (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       base_tick,
  input  wire logic [7:0] duty,
  input  wire logic [1:0] div_sel,
  output logic            pwm_q
);

  logic [9:0] cnt_q, cnt_d;
  logic [7:0] duty_q, duty_d;
  logic [1:0] div_q, div_d;
  logic       pwm_d;
  logic       last;

  function automatic logic level(input logic [9:0] c, input logic [7:0] d,
                                 input logic [1:0] v);
    case (v)
      cprot_pkg::DIV_1024: return c[9:2] < d;
      cprot_pkg::DIV_512:  return c[8:1] < d;
      cprot_pkg::DIV_256:  return c[7:0] < d;
      default:             return 1'b1;
    endcase
  endfunction

  // ************************************************************
  // Period counter with settings taken only at a period boundary
  // ************************************************************
  always_comb begin
    case (div_q)
      cprot_pkg::DIV_1024: last = cnt_q == 10'h3ff;
      cprot_pkg::DIV_512:  last = cnt_q[8:0] == 9'h1ff;
      default:             last = cnt_q[7:0] == 8'hff;
    endcase
    cnt_d  = cnt_q;
    duty_d = duty_q;
    div_d  = div_q;
    if (base_tick) begin
      if (last) begin
        cnt_d  = 10'h000;
        duty_d = duty;
        div_d  = div_sel;
      end else begin
        cnt_d = cnt_q + 10'h001;
      end
    end
    pwm_d = level(cnt_d, duty_d, div_d);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q  <= 10'h000;
      duty_q <= cprot_pkg::DUTY_RST;
      div_q  <= cprot_pkg::DIV_RST;
      pwm_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      duty_q <= duty_d;
      div_q  <= div_d;
      pwm_q  <= pwm_d;
    end
  end

endmodule // cprot_pwm_gen

/* File: testbench/cprot_load_model.sv */
// Load model for the eight outputs, with a per-channel short.
module cprot_load_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] ch_on,
  input  wire logic [7:0] short_q,
  input  wire logic [1:0] hs_sense,
  output logic      [7:0] ovl_det,
  output logic      [1:0] ovl_hs_det
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Overload current
  // ************************************************************
  logic [7:0] hot_q;
  // A shorted load draws overload current only while its channel conducts.
  always_ff @(posedge clk_sys) begin
    hot_q <= ch_on & short_q;
  end
  assign ovl_det    = hot_q & ~{4'h0, hs_sense, 2'h0};
  assign ovl_hs_det = hot_q[3:2] & hs_sense;
endmodule // cprot_load_model

/* File: testbench/tb.sv */
// Self-checking testbench for the channel protection and PWM block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TMO = 200;
  localparam int unsigned RSC = 20;
  logic       clk_sys   = 1'b0;
  logic       sys_rst   = 1'b1;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] ot_det    = 8'h00;
  logic [7:0] inv_det   = 8'h00;
  logic [1:0] hs_sense  = 2'h0;
  logic [7:0] in_pin    = 8'h00;
  logic [7:0] short_q   = 8'h00;
  logic [7:0] ovl_det;
  logic [1:0] ovl_hs_det;
  logic [7:0] ch_on;
  int         mismatches = 0;
  int         checked    = 0;

  always #5 clk_sys = ~clk_sys;

  cprot_ctrl #(.TMO_CYC(TMO), .RESTART_CYC(RSC)) i_cprot_ctrl (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ovl_det(ovl_det),
    .ot_det(ot_det), .inv_det(inv_det), .ovl_hs_det(ovl_hs_det), .hs_sense(hs_sense),
    .in_pin(in_pin), .ch_on(ch_on));
  cprot_load_model i_cprot_load_model (
    .clk_sys(clk_sys), .ch_on(ch_on), .short_q(short_q), .hs_sense(hs_sense),
    .ovl_det(ovl_det), .ovl_hs_det(ovl_hs_det));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
    chk(what, {8'h00, d}, {8'h00, exp});
    @(posedge clk_sys);
  endtask

  task automatic wait_ch(input string what, input int c, input logic v, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge clk_sys);
      if (ch_on[c] === v) break;
    end
    chk(what, 16'(n < lim), 16'h0001);
    @(posedge clk_sys);
  endtask

  task automatic meas(input int c, output int hi, output int lo);
    int n;
    hi = 0;
    lo = 0;
    for (n = 0; n < 20000; n++) begin
      @(negedge clk_sys);
      if (ch_on[c] === 1'b0) break;
    end
    for (n = 0; n < 20000; n++) begin
      @(negedge clk_sys);
      if (ch_on[c] === 1'b1) break;
    end
    while (ch_on[c] === 1'b1 && hi < 20000) begin
      @(negedge clk_sys);
      hi++;
    end
    while (ch_on[c] === 1'b0 && lo < 20000) begin
      @(negedge clk_sys);
      lo++;
    end
    @(posedge clk_sys);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    logic [7:0] e;
    wr(4'he, 8'h5a);
    for (int a = 0; a < 16; a++) begin
      e = (4'(a) == cprot_pkg::ADDR_TRIM) ? 8'(cprot_pkg::TRIM_RST) : 8'h00;
      rdc("reset value", 4'(a), e);
    end
    $display("test reset done");
  endtask

  task automatic t_overload();
    int c;
    hs_sense <= 2'h2;
    for (int i = 0; i < 2; i++) begin
      c = i * 3;
      wr(cprot_pkg::ADDR_OUT, 8'(1 << c));
      wt(4);
      short_q <= 8'(1 << c);
      wait_ch("latch off", c, 1'b0, 12);
      rdc("error flag", cprot_pkg::ADDR_ERR, 8'(1 << c));
      wt(30);
      rdc("stays off", cprot_pkg::ADDR_STATE, 8'h00);
      short_q <= 8'h00;
      wr(cprot_pkg::ADDR_OCL, 8'(1 << c));
      wait_ch("on after clear", c, 1'b1, 8);
      rdc("error cleared", cprot_pkg::ADDR_ERR, 8'h00);
      wr(cprot_pkg::ADDR_OUT, 8'h00);
    end
    $display("test overload done");
  endtask

  task automatic t_pair();
    int a;
    int b;
    for (int p = 0; p < 4; p++) begin
      a = (p & 1) + (p & 2) * 2;
      b = a + 2;
      wr(cprot_pkg::ADDR_PAIR, 8'(1 << p));
      wr(cprot_pkg::ADDR_OUT, 8'(1 << a));
      wt(4);
      rdc("single switch", cprot_pkg::ADDR_STATE, 8'(1 << a));
      wr(cprot_pkg::ADDR_OUT, 8'(1 << a | 1 << b));
      wt(4);
      short_q <= 8'(1 << a);
      wait_ch("partner off", b, 1'b0, 12);
      short_q <= 8'h00;
      wr(cprot_pkg::ADDR_OUT, 8'h00);
      wr(cprot_pkg::ADDR_OCL, 8'hff);
    end
    wr(cprot_pkg::ADDR_PAIR, 8'h00);
    $display("test pair done");
  endtask

  task automatic t_retry();
    wr(cprot_pkg::ADDR_RETRY, 8'h02);
    rdc("retry select", cprot_pkg::ADDR_RETRY, 8'h02);
    short_q <= 8'h02;
    wr(cprot_pkg::ADDR_OUT, 8'h02);
    wait_ch("retry off", 1, 1'b0, 12);
    rdc("retry error", cprot_pkg::ADDR_ERR, 8'h02);
    wait_ch("auto restart", 1, 1'b1, RSC + 12);
    wt(TMO);
    rdc("retry timeout", cprot_pkg::ADDR_RETRY, 8'h00);
    wt(2 * RSC);
    rdc("latched", cprot_pkg::ADDR_STATE, 8'h00);
    wt(9);
    rdc("still latched", cprot_pkg::ADDR_STATE, 8'h00);
    rdc("latch flag", cprot_pkg::ADDR_LATCH, 8'h02);
    short_q <= 8'h00;
    wr(cprot_pkg::ADDR_OUT, 8'h00);
    wr(cprot_pkg::ADDR_OCL, 8'hff);
    $display("test retry done");
  endtask

  task automatic t_off_clear();
    wr(cprot_pkg::ADDR_RETRY, 8'hc0);
    wr(cprot_pkg::ADDR_OUT, 8'h40);
    in_pin <= 8'h80;
    wt(6);
    rdc("retry held", cprot_pkg::ADDR_RETRY, 8'hc0);
    wr(cprot_pkg::ADDR_OUT, 8'h00);
    in_pin <= 8'h00;
    wt(6);
    rdc("retry off clear", cprot_pkg::ADDR_RETRY, 8'h00);
    $display("test off clear done");
  endtask

  task automatic t_inverse();
    wr(cprot_pkg::ADDR_OUT, 8'h30);
    inv_det <= 8'h10;
    wt(6);
    short_q <= 8'h30;
    ot_det  <= 8'h10;
    wt(20);
    rdc("inverse hold", cprot_pkg::ADDR_STATE, 8'h10);
    rdc("inverse error", cprot_pkg::ADDR_ERR, 8'h30);
    inv_det <= 8'h00;
    wait_ch("protect again", 4, 1'b0, 12);
    short_q <= 8'h00;
    ot_det  <= 8'h00;
    wr(cprot_pkg::ADDR_OUT, 8'h00);
    wr(cprot_pkg::ADDR_OCL, 8'hff);
    $display("test inverse done");
  endtask

  task automatic t_pwm();
    int hi;
    int lo;
    int n;
    wr(cprot_pkg::ADDR_DUTY0, 8'h40);
    wr(cprot_pkg::ADDR_DIV0, 8'(cprot_pkg::DIV_256));
    wr(cprot_pkg::ADDR_DUTY1, 8'h80);
    wr(cprot_pkg::ADDR_DIV1, 8'(cprot_pkg::DIV_512));
    wr(cprot_pkg::ADDR_PWM_MAP, 8'h80);
    wr(cprot_pkg::ADDR_PWM_EN, 8'hc0);
    meas(6, hi, lo);
    chk("gen0 high", 16'(hi), 16'h0400);
    chk("gen0 low", 16'(lo), 16'h0c00);
    meas(7, hi, lo);
    chk("gen1 high", 16'(hi), 16'h1000);
    chk("gen1 low", 16'(lo), 16'h1000);
    wr(cprot_pkg::ADDR_DUTY0, 8'hff);
    meas(6, hi, lo);
    chk("max duty low", 16'(lo), 16'h0010);
    chk("max duty high", 16'(hi), 16'h0ff0);
    wr(cprot_pkg::ADDR_DIV0, 8'(cprot_pkg::DIV_FULL));
    wt(4200);
    n = 0;
    repeat (4200) begin
      @(negedge clk_sys);
      if (ch_on[6] !== 1'b1) n++;
    end
    @(posedge clk_sys);
    chk("full on", 16'(n), 16'h0000);
    wr(cprot_pkg::ADDR_DIV0, 8'(cprot_pkg::DIV_256));
    wr(cprot_pkg::ADDR_DUTY0, 8'h80);
    wr(cprot_pkg::ADDR_PWM_EN, 8'h40);
    wr(cprot_pkg::ADDR_TRIM, 8'h0f);
    meas(6, hi, lo);
    chk("trim fast", 16'(hi + lo > 2870 && hi + lo < 2980), 16'h0001);
    wr(cprot_pkg::ADDR_TRIM, 8'h01);
    meas(6, hi, lo);
    chk("trim slow", 16'(hi + lo > 6400 && hi + lo < 6650), 16'h0001);
    $display("test pwm done");
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_overload();
    t_pair();
    t_retry();
    t_off_clear();
    t_inverse();
    t_pwm();
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    give_verdict();
  end
endmodule // tb
